// File: src/tgs_defines.vh
// constants for the trigger and digital i/o sequencer
`ifndef TGS_DEFINES_VH
`define TGS_DEFINES_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TGS_OFF_CTRL        12'h000
`define TGS_OFF_DOUT        12'h004
`define TGS_OFF_DELAY       12'h008
`define TGS_OFF_SETTING     12'h00c
`define TGS_OFF_COMPLY      12'h010
`define TGS_OFF_STATUS      12'h014
`define TGS_OFF_INPUT       12'h018
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define TGS_CTRL_CONT       0
`define TGS_CTRL_FUNC0      1
`define TGS_CTRL_FUNC1      2
`define TGS_CTRL_OUT_EN     3
`define TGS_CTRL_AC_MODE    4
`define TGS_CTRL_AC_HV      5
`define TGS_CTRL_RANGE_LSB  8
`define TGS_CTRL_RANGE_W    3
// ---------------------------------------------------------------
// status bits
// ---------------------------------------------------------------
`define TGS_ST_WAIT_EVENT   5
`define TGS_ST_ARM          6
`define TGS_ST_IDLE         10
`define TGS_ST_COMPLIANCE   16
`define TGS_ST_HV_STAGE     17
`define TGS_ST_BUSY         18
// ---------------------------------------------------------------
// compliance setting, tenths of a volt
// ---------------------------------------------------------------
`define TGS_COMP_MIN        12'h00a
`define TGS_COMP_LV_MAX     12'h064
`define TGS_COMP_MAX        12'h3e8
`define TGS_RANGE_TOP       3'h5
`define TGS_COMP_RESET      12'h064
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TGS_CLK_HZ          50000000
`define TGS_PULSE_NS        5000
`define TGS_CLK_NS          20
`define TGS_PULSE_CYC       (`TGS_PULSE_NS / `TGS_CLK_NS)
`define TGS_MS_CYC          (`TGS_CLK_HZ / 1000)
`define TGS_DEBOUNCE_MS     1000
`define TGS_APPLY_CYC       2
`endif

// File: src/tgs_debounce.v
// compliance annunciator with a slow release
`timescale 1ns/1ps
module tgs_debounce #(
  parameter HOLD_MS = 1000,
  parameter MS_CYC = 50000
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // condition
  input wire in_comply,
  output reg flag_reg
);
  reg [15:0] tick_reg;
  reg [15:0] ms_reg;
  wire tick = (tick_reg == MS_CYC - 1);

  // sets at once, clears after a steady second out of compliance
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_reg <= 16'h0000;
      ms_reg <= 16'h0000;
      flag_reg <= 1'b0;
    end else if (in_comply) begin
      tick_reg <= 16'h0000;
      ms_reg <= 16'h0000;
      flag_reg <= 1'b1;
    end else if (flag_reg) begin
      tick_reg <= tick ? 16'h0000 : tick_reg + 16'h0001;
      if (tick) begin
        if (ms_reg == HOLD_MS - 1) begin
          flag_reg <= 1'b0;
          ms_reg <= 16'h0000;
        end else begin
          ms_reg <= ms_reg + 16'h0001;
        end
      end
    end
  end
endmodule // tgs_debounce

// File: src/tgs_trigger_gpio_sequencer.v
// digital i/o and trigger-out sequencer with apb registers
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tgs_defines.vh"
module tgs_trigger_gpio_sequencer #(
  parameter DEBOUNCE_MS = `TGS_DEBOUNCE_MS,
  parameter MS_CYC = `TGS_MS_CYC,
  parameter PULSE_CYC = `TGS_PULSE_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // digital pins
  input wire [1:0] din_pin,
  output reg [1:0] dout_pin,
  // source side
  input wire in_comply,
  output reg apply_strobe,
  output reg hv_stage,
  output reg comply_flag
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  // binary state codes, idle is the reset state
  localparam ST_IDLE = 3'd0;
  localparam ST_DETECT = 3'd1;
  localparam ST_APPLY = 3'd2;
  localparam ST_DELAY = 3'd3;
  localparam ST_PULSE = 3'd4;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [1:0] din_meta_reg;
  reg [1:0] din_sync_reg;
  reg cont_reg;
  reg [1:0] func_reg;
  reg out_en_reg;
  reg ac_mode_reg;
  reg ac_hv_reg;
  reg [2:0] range_reg;
  reg [1:0] level_reg;
  reg [15:0] delay_reg;
  reg [31:0] setting_reg;
  reg [11:0] comp_reg;
  reg event_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] tick_reg;
  reg [15:0] ms_reg;
  reg [15:0] pulse_reg;
  reg [1:0] apply_reg;
  wire comply_db;

  // writes land only at the edge where the master sees pready high
  wire wr_en = psel & penable & pwrite & pready;
  wire rd_en = psel & penable & ~pwrite;
  wire mapped = (paddr == `TGS_OFF_CTRL) | (paddr == `TGS_OFF_DOUT) |
                (paddr == `TGS_OFF_DELAY) | (paddr == `TGS_OFF_SETTING) |
                (paddr == `TGS_OFF_COMPLY) | (paddr == `TGS_OFF_STATUS) |
                (paddr == `TGS_OFF_INPUT);
  wire in_idle = (state_reg == ST_IDLE);
  wire in_detect = (state_reg == ST_DETECT);
  wire top_range = (range_reg == `TGS_RANGE_TOP);
  wire ms_tick = (tick_reg == MS_CYC - 1);

  // clamp compliance setting to the allowed window for the range
  function [11:0] clamp_comp;
    input [11:0] v;
    input top;
    begin
      if (v < `TGS_COMP_MIN)
        clamp_comp = `TGS_COMP_MIN;
      else if (top && v > `TGS_COMP_LV_MAX)
        clamp_comp = `TGS_COMP_LV_MAX;
      else if (v > `TGS_COMP_MAX)
        clamp_comp = `TGS_COMP_MAX;
      else
        clamp_comp = v;
    end
  endfunction

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      din_meta_reg <= 2'h0;
      din_sync_reg <= 2'h0;
    end else begin
      // only the second flop feeds any logic
      din_meta_reg <= din_pin;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // register writes and event capture
  // ---------------------------------------------------------------
  wire ctrl_wr = wr_en & (paddr == `TGS_OFF_CTRL);
  wire set_wr = wr_en & (paddr == `TGS_OFF_SETTING);
  wire comp_wr = wr_en & (paddr == `TGS_OFF_COMPLY);
  wire [2:0] range_wdata = pwdata[`TGS_CTRL_RANGE_LSB +: `TGS_CTRL_RANGE_W];
  wire new_out_en = ctrl_wr ? pwdata[`TGS_CTRL_OUT_EN] : out_en_reg;
  // any listed setting change, or the output being turned on
  wire ctrl_change = ctrl_wr & ((pwdata[`TGS_CTRL_OUT_EN] & ~out_en_reg) |
                     (pwdata[`TGS_CTRL_AC_MODE] != ac_mode_reg) |
                     (pwdata[`TGS_CTRL_AC_HV] != ac_hv_reg) |
                     (range_wdata != range_reg));
  wire setting_event = (ctrl_change | set_wr | comp_wr) & new_out_en;

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cont_reg <= 1'b0;
      func_reg <= 2'h0;
      out_en_reg <= 1'b0;
      ac_mode_reg <= 1'b0;
      ac_hv_reg <= 1'b0;
      range_reg <= 3'h0;
      level_reg <= 2'h0;
      delay_reg <= 16'h0000;
      setting_reg <= 32'h0000_0000;
      comp_reg <= `TGS_COMP_RESET;
      event_reg <= 1'b0;
    end else begin
      // a range change re-clamps the stored compliance setting
      if (ctrl_wr) begin
        cont_reg <= pwdata[`TGS_CTRL_CONT];
        func_reg <= {pwdata[`TGS_CTRL_FUNC1], pwdata[`TGS_CTRL_FUNC0]};
        out_en_reg <= pwdata[`TGS_CTRL_OUT_EN];
        ac_mode_reg <= pwdata[`TGS_CTRL_AC_MODE];
        ac_hv_reg <= pwdata[`TGS_CTRL_AC_HV];
        range_reg <= range_wdata;
        comp_reg <= clamp_comp(comp_reg, range_wdata == `TGS_RANGE_TOP);
      end
      if (wr_en && paddr == `TGS_OFF_DOUT)
        level_reg <= pwdata[1:0];
      if (wr_en && paddr == `TGS_OFF_DELAY)
        delay_reg <= pwdata[15:0];
      if (set_wr)
        setting_reg <= pwdata;
      if (comp_wr)
        comp_reg <= clamp_comp(pwdata[11:0], top_range);
      // set wins over the consume of the detect state
      if (setting_event && in_detect)
        event_reg <= 1'b1;
      else if (state_reg != ST_DETECT)
        event_reg <= 1'b0;
      else if (event_reg)
        event_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // trigger sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    // events during apply, delay and pulse are dropped
    case (state_reg)
      ST_IDLE:
        if (cont_reg)
          state_next = ST_DETECT;
      ST_DETECT:
        if (!cont_reg)
          state_next = ST_IDLE;
        else if (event_reg)
          state_next = ST_APPLY;
      ST_APPLY:
        if (!cont_reg)
          state_next = ST_IDLE;
        else if (apply_reg == `TGS_APPLY_CYC - 1)
          state_next = ST_DELAY;
      ST_DELAY:
        if (!cont_reg)
          state_next = ST_IDLE;
        else if (ms_reg >= delay_reg)
          state_next = ST_PULSE;
      ST_PULSE:
        if (pulse_reg == PULSE_CYC - 1)
          state_next = cont_reg ? ST_DETECT : ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      tick_reg <= 16'h0000;
      ms_reg <= 16'h0000;
      pulse_reg <= 16'h0000;
      apply_reg <= 2'h0;
      apply_strobe <= 1'b0;
    end else begin
      state_reg <= state_next;
      apply_strobe <= in_detect & event_reg & cont_reg;
      apply_reg <= (state_reg == ST_APPLY) ? apply_reg + 2'h1 : 2'h0;
      // the ms counter restarts whenever the delay state is left
      if (state_reg == ST_DELAY && state_next == ST_DELAY) begin
        tick_reg <= ms_tick ? 16'h0000 : tick_reg + 16'h0001;
        if (ms_tick)
          ms_reg <= ms_reg + 16'h0001;
      end else begin
        tick_reg <= 16'h0000;
        ms_reg <= 16'h0000;
      end
      pulse_reg <= (state_reg == ST_PULSE) ? pulse_reg + 16'h0001 : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // output pins
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_out
      always @(posedge core_clk or posedge reset) begin
        if (reset)
          dout_pin[i] <= 1'b1;
        // trigger pins idle high and go low during the pulse state
        else if (func_reg[i])
          dout_pin[i] <= ~(state_next == ST_PULSE);
        else
          dout_pin[i] <= level_reg[i];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // output stage and compliance annunciator
  // ---------------------------------------------------------------
  tgs_debounce #(
    .HOLD_MS(DEBOUNCE_MS),
    .MS_CYC(MS_CYC)
  ) u_debounce (
    .core_clk(core_clk),
    .reset(reset),
    .in_comply(in_comply),
    .flag_reg(comply_db)
  );

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hv_stage <= 1'b0;
      comply_flag <= 1'b0;
    end else begin
      comply_flag <= comply_db;
      // ac mode uses the select bit, forced low in the top range, dc mode the compliance setting
      if (ac_mode_reg)
        hv_stage <= ac_hv_reg & ~top_range;
      else
        hv_stage <= (comp_reg > `TGS_COMP_LV_MAX);
    end
  end

  // ---------------------------------------------------------------
  // apb read and answer
  // ---------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `TGS_OFF_CTRL: begin
        rd_mux[`TGS_CTRL_CONT] = cont_reg;
        rd_mux[`TGS_CTRL_FUNC0] = func_reg[0];
        rd_mux[`TGS_CTRL_FUNC1] = func_reg[1];
        rd_mux[`TGS_CTRL_OUT_EN] = out_en_reg;
        rd_mux[`TGS_CTRL_AC_MODE] = ac_mode_reg;
        rd_mux[`TGS_CTRL_AC_HV] = ac_hv_reg;
        rd_mux[`TGS_CTRL_RANGE_LSB +: `TGS_CTRL_RANGE_W] = range_reg;
      end
      `TGS_OFF_DOUT: rd_mux[1:0] = level_reg;
      `TGS_OFF_DELAY: rd_mux[15:0] = delay_reg;
      `TGS_OFF_SETTING: rd_mux = setting_reg;
      `TGS_OFF_COMPLY: rd_mux[11:0] = comp_reg;
      `TGS_OFF_STATUS: begin
        rd_mux[`TGS_ST_WAIT_EVENT] = in_detect;
        rd_mux[`TGS_ST_ARM] = 1'b0;
        rd_mux[`TGS_ST_IDLE] = in_idle;
        rd_mux[`TGS_ST_COMPLIANCE] = comply_flag;
        rd_mux[`TGS_ST_HV_STAGE] = hv_stage;
        rd_mux[`TGS_ST_BUSY] = ~in_idle & ~in_detect;
      end
      `TGS_OFF_INPUT: rd_mux[1:0] = din_sync_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // one wait state: ready rises in the second access cycle
      pready <= psel & penable & ~pready;
      // unmapped offsets answer with an error, and reads of them with zero data
      pslverr <= psel & penable & ~pready & ~mapped;
      if (rd_en && !pready)
        prdata <= rd_mux;
    end
  end
endmodule // tgs_trigger_gpio_sequencer

// File: testbench/tgs_checker_asserts.sv
// assertions on the sequencer's top-level ports
`timescale 1ns/1ps
module tgs_checker #(
  parameter DEBOUNCE_MS = 3,
  parameter MS_CYC = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and source side
  input wire logic [1:0] dout_pin,
  input wire logic in_comply,
  input wire logic apply_strobe,
  input wire logic comply_flag
);
  localparam int N = DEBOUNCE_MS * MS_CYC;
  logic [15:0] low_reg;
  // -------------------------------------------------------------
  // consecutive cycles out of compliance
  // -------------------------------------------------------------
  always @(posedge core_clk or posedge reset) begin
    if (reset) low_reg <= 16'h0000;
    else if (in_comply) low_reg <= 16'h0000;
    else if (low_reg != 16'hffff) low_reg <= low_reg + 16'h0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_ready; $rose(psel && penable) |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("access not answered");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_apply; apply_strobe |=> !apply_strobe ##0 $stable(dout_pin)[*2]; endproperty
  a_apply: assert property (p_apply) else $error("pulse before setting applied");
  property p_set; $rose(in_comply) |-> ##[1:3] comply_flag; endproperty
  a_set: assert property (p_set) else $error("annunciator slow to set");
  property p_hold; comply_flag && low_reg < N - 2 |=> comply_flag; endproperty
  a_hold: assert property (p_hold) else $error("annunciator released early");
  property p_clear; low_reg == N + 4 |-> !comply_flag; endproperty
  a_clear: assert property (p_clear) else $error("annunciator never released");
  property p_flag_src; $rose(comply_flag) |-> $past(in_comply, 2) || $past(in_comply); endproperty
  a_flag_src: assert property (p_flag_src) else $error("annunciator set without cause");
endmodule // tgs_checker
bind tgs_trigger_gpio_sequencer tgs_checker #(.DEBOUNCE_MS(DEBOUNCE_MS), .MS_CYC(MS_CYC)) u_chk (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dout_pin(dout_pin), .in_comply(in_comply), .apply_strobe(apply_strobe),
  .comply_flag(comply_flag));

// File: testbench/tgs_meter_model.sv
// meter taking trigger pulses, plus input sources
`timescale 1ns/1ps
module tgs_meter_model (
  // clock
  input wire logic core_clk,
  // trigger line and source side
  input wire logic trig_n,
  input wire logic apply_strobe,
  input wire logic [1:0] level_set,
  output logic [1:0] din_pin,
  // measurements
  output int pulses,
  output int width,
  output int gap
);
  logic last_reg = 1'b1;
  int run_reg;
  int since_reg;
  assign din_pin = level_set;
  // -------------------------------------------------------------
  // low pulse count, width and distance from the apply strobe
  // -------------------------------------------------------------
  always @(posedge core_clk) begin
    last_reg <= trig_n;
    since_reg <= apply_strobe ? 0 : since_reg + 1;
    if (last_reg && !trig_n) begin
      pulses <= pulses + 1;
      gap <= since_reg;
      run_reg <= 1;
    end else if (!trig_n) run_reg <= run_reg + 1;
    if (!last_reg && trig_n) width <= run_reg;
  end
endmodule // tgs_meter_model

// File: testbench/tb_tgs_trigger_gpio_sequencer.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
`include "tgs_defines.vh"
module tb_tgs_trigger_gpio_sequencer;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, in_comply = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, apply_strobe, hv_stage, comply_flag;
  logic [1:0] din_pin, dout_pin, level_set = 2'b00;
  int pulses, width, gap, p0, n, mismatches = 0, num_checks = 0, cyc = 0;
  logic [11:0] ev_a [4] = '{`TGS_OFF_CTRL, `TGS_OFF_SETTING, `TGS_OFF_COMPLY, `TGS_OFF_CTRL};
  logic [31:0] ev_d [4] = '{32'h00b, 32'h005, 32'h032, 32'h10b};
  tgs_trigger_gpio_sequencer #(.DEBOUNCE_MS(3), .MS_CYC(10), .PULSE_CYC(250)) dut (.core_clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .din_pin, .dout_pin, .in_comply,
    .apply_strobe, .hv_stage, .comply_flag);
  tgs_meter_model u_meter (.core_clk, .trig_n(dout_pin[0]), .apply_strobe, .level_set, .din_pin, .pulses,
    .width, .gap);
  initial forever #10 core_clk = ~core_clk;
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin @(posedge core_clk); end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("[FAIL] %0t run too long", $time);
      print_verdict;
    end
  end
  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    apb(0, `TGS_OFF_STATUS, 0);
    chk(r & 32'h00020460, 32'h00000400);
    chk(32'(dout_pin), 32'h0);
    for (int i = 0; i < 4; i++) begin
      level_set <= 2'(i);
      repeat (5) @(posedge core_clk);
      apb(0, `TGS_OFF_INPUT, 0);
      chk(r & 32'h3, 32'(i));
    end
    apb(1, `TGS_OFF_CTRL, 32'h2);
    apb(1, `TGS_OFF_DOUT, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(32'(dout_pin), 32'h1);
    apb(1, `TGS_OFF_DOUT, 32'h3);
    repeat (2) @(posedge core_clk);
    chk(32'(dout_pin), 32'h3);
    apb(0, 12'h01c, 0);
    chk({r[30:0], e}, 32'h1);
    $display("idle and pin tests done");
    apb(1, `TGS_OFF_DELAY, 32'h2);
    apb(1, `TGS_OFF_CTRL, 32'h3);
    apb(0, `TGS_OFF_STATUS, 0);
    chk(r & 32'h460, 32'h20);
    p0 = pulses;
    apb(1, `TGS_OFF_SETTING, 32'h1);
    repeat (400) @(posedge core_clk);
    chk(32'(pulses - p0), 0);
    for (int k = 0; k < 4; k++) begin
      p0 = pulses;
      apb(1, ev_a[k], ev_d[k]);
      for (n = 0; n < 600 && !(pulses > p0 && dout_pin[0]); n++) @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      chk(32'(pulses - p0), 1);
      chk(32'(width), 250);
      chk(32'(gap >= 20 && gap <= 24), 1);
      apb(0, `TGS_OFF_STATUS, 0);
      chk(r & 32'h460, 32'h20);
    end
    apb(1, `TGS_OFF_CTRL, 32'h10a);
    apb(0, `TGS_OFF_STATUS, 0);
    chk(r & 32'h460, 32'h400);
    p0 = pulses;
    apb(1, `TGS_OFF_SETTING, 32'h7);
    repeat (400) @(posedge core_clk);
    chk(32'(pulses - p0), 0);
    $display("trigger tests done");
    apb(1, `TGS_OFF_CTRL, 32'h00a);
    apb(1, `TGS_OFF_COMPLY, 32'h065);
    apb(0, `TGS_OFF_STATUS, 0);
    chk({r[17], 30'h0, hv_stage}, 32'h80000001);
    apb(1, `TGS_OFF_COMPLY, 32'h064);
    repeat (2) @(posedge core_clk);
    chk(32'(hv_stage), 0);
    apb(1, `TGS_OFF_COMPLY, 32'h005);
    apb(0, `TGS_OFF_COMPLY, 0);
    chk(r & 32'hfff, 32'h00a);
    apb(1, `TGS_OFF_COMPLY, 32'h7d0);
    apb(0, `TGS_OFF_COMPLY, 0);
    chk(r & 32'hfff, 32'h3e8);
    apb(1, `TGS_OFF_CTRL, 32'h50a);
    apb(0, `TGS_OFF_COMPLY, 0);
    chk(r & 32'hfff, 32'h064);
    apb(1, `TGS_OFF_CTRL, 32'h03a);
    repeat (2) @(posedge core_clk);
    chk(32'(hv_stage), 1);
    apb(1, `TGS_OFF_CTRL, 32'h53a);
    repeat (2) @(posedge core_clk);
    chk(32'(hv_stage), 0);
    in_comply <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'(comply_flag), 1);
    apb(0, `TGS_OFF_STATUS, 0);
    chk(r & 32'h10000, 32'h10000);
    in_comply <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(32'(comply_flag), 1);
    repeat (20) @(posedge core_clk);
    chk(32'(comply_flag), 0);
    $display("stage and compliance tests done");
    print_verdict;
  end
endmodule // tb_tgs_trigger_gpio_sequencer
